// >>> shared/lvds_serializer_pkg.sv
// constants, map and types of the 28-bit to 4-lane 7:1 pixel serializer
// assumes a 250 MHz sampling clock, well above the pixel rate
package lvds_serializer_pkg;

   localparam int LANE_COUNT = 4;
   localparam int SLOT_COUNT = 7;
   localparam int PIXEL_BITS = 28;
   localparam int FWD_HIGH_SLOTS = 4;
   localparam int CLK_FREQ_MHZ = 250;

   // pixel clock period window and spread-spectrum depths
   localparam int PER_MIN_PS = 7400;
   localparam int PER_MAX_NS = 100;
   localparam int SSC_DEPTH_30K_PCT = 8;
   localparam int SSC_DEPTH_50K_PCT = 6;
   localparam int SSC_DEPTH_PCT = (SSC_DEPTH_30K_PCT > SSC_DEPTH_50K_PCT) ?
      SSC_DEPTH_30K_PCT : SSC_DEPTH_50K_PCT;
   localparam int PER_MIN_CYC_INT = (PER_MIN_PS * CLK_FREQ_MHZ + 999999) / 1000000;
   localparam int PER_LOW_INT = (PER_MIN_CYC_INT > SLOT_COUNT) ? PER_MIN_CYC_INT : SLOT_COUNT;
   localparam int PER_HIGH_INT = (PER_MAX_NS * CLK_FREQ_MHZ / 1000) * (100 + SSC_DEPTH_PCT) / 100;
   localparam logic [7:0] PER_LOW = 8'(PER_LOW_INT);
   localparam logic [7:0] PER_HIGH = 8'(PER_HIGH_INT);
   localparam logic [7:0] SLOT_STEP = 8'(SLOT_COUNT);

   // enable and disable times
   localparam int LOCK_TIME_NS = 6000;
   localparam int LOCK_CYCLES_INT = LOCK_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam logic [10:0] LOCK_CYCLES = 11'(LOCK_CYCLES_INT);
   localparam int DIS_TIME_NS = 7;
   localparam int DIS_CYC_RAW = DIS_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int DIS_CYCLES = (DIS_CYC_RAW < 1) ? 1 : DIS_CYC_RAW;

   typedef logic [PIXEL_BITS-1:0] pixel_t;
   typedef logic [4:0] bit_index_t;

   // parallel bit sent in each slot, per lane
   localparam bit_index_t SLOT_MAP [0:SLOT_COUNT-1][0:LANE_COUNT-1] = '{
      '{5'h01, 5'h09, 5'h14, 5'h05},
      '{5'h00, 5'h08, 5'h13, 5'h1B},
      '{5'h07, 5'h12, 5'h1A, 5'h17},
      '{5'h06, 5'h0F, 5'h19, 5'h11},
      '{5'h04, 5'h0E, 5'h18, 5'h10},
      '{5'h03, 5'h0D, 5'h16, 5'h0B},
      '{5'h02, 5'h0C, 5'h15, 5'h0A}
   };

   // link side pins
   typedef struct packed {
      logic [LANE_COUNT-1:0] serialLaneOut;
      logic forwardedLinkClock;
      logic linkOeN;
      logic laneValid;
   } link_out_t;

   // whole state of the serializer
   typedef struct packed {
      logic clkS1;
      logic clkS2;
      logic clkPrev;
      logic selS1;
      logic selS2;
      logic sdnS1;
      logic sdnS2;
      pixel_t dataS1;
      pixel_t dataS2;
      pixel_t dataPrev;
      logic [7:0] perCnt;
      logic [7:0] perMeas;
      logic [7:0] acc;
      logic [2:0] slot;
      logic [LANE_COUNT-1:0][SLOT_COUNT-1:0] words;
      logic [10:0] lockCnt;
      logic locked;
      link_out_t out;
   } state_t;

endpackage

// >>> rtl/lvds_seven_to_one_serializer.sv
// 28-bit to 4-lane 7:1 pixel serializer with forwarded link clock
// assumes pixel clock, data, select and shutdown pins are asynchronous to ref_clk
// Behaviour
// - tolerate 8% spread at 30 kHz
// - tolerate 6% spread at 50 kHz
// - seven slots whose lengths differ by one cycle at most, slot 0 at clock rise
// - slot 0 lanes carry bits 1,9,20,5
// - slot 1 lanes carry bits 0,8,19,27
// - slot 2 lanes carry bits 7,18,26,23
// - slot 3 lanes carry bits 6,15,25,17
// - slot 4 lanes carry bits 4,14,24,16
// - slot 5 lanes carry bits 3,13,22,11
// - slot 6 lanes carry bits 2,12,21,10
// - link clock high four of seven slots
// - lock then valid data after shutdown release
// - shutdown floats the link clock output quickly
// - capture edge chosen by edge-select level
`timescale 1ns/100ps

module lvds_seven_to_one_serializer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // parallel pixel side
   input wire logic pixelClockIn,
   input wire lvds_serializer_pkg::pixel_t parallelPixelBits,
   input wire logic captureEdgeSelect,
   input wire logic shutdownN,
   // serial link side
   output lvds_serializer_pkg::link_out_t linkOut
);
   import lvds_serializer_pkg::*;

   // shutdown must float the outputs within this many cycles of the synced level
   localparam int DIS_BOUND = DIS_CYCLES;

   logic [1:0] rstPipe;
   logic rstSync;
   state_t st;
   state_t next_st;
   logic riseSeen;
   logic fallSeen;
   logic pixEdge;
   logic periodGood;
   logic stalled;
   logic [7:0] slotSum;
   pixel_t heldPixel;
   logic [3:0] quietCnt;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync = rstPipe[1];

   // edge detection on the synchronised pixel clock
   assign riseSeen = st.clkS2 & ~st.clkPrev;
   assign fallSeen = ~st.clkS2 & st.clkPrev;
   assign pixEdge = st.selS2 ? riseSeen : fallSeen;
   assign stalled = (st.perCnt > PER_HIGH);
   assign slotSum = st.acc + SLOT_STEP;

   // next state
   always_comb begin
      next_st = st;
      periodGood = 1'b0;
      // two-flop synchronisers for every pin
      // data shares the clock's latency, so the word captured is the one before the edge
      next_st.clkS1 = pixelClockIn;
      next_st.clkS2 = st.clkS1;
      next_st.clkPrev = st.clkS2;
      next_st.selS1 = captureEdgeSelect;
      next_st.selS2 = st.selS1;
      next_st.sdnS1 = shutdownN;
      next_st.sdnS2 = st.sdnS1;
      next_st.dataS1 = parallelPixelBits;
      next_st.dataS2 = st.dataS1;
      next_st.dataPrev = st.dataS2;

      // period is re-measured every pixel period to follow spread spectrum
      // a count above PER_HIGH means the pixel clock has stopped
      if (pixEdge) begin
         next_st.perMeas = (st.perCnt == 8'hFF) ? st.perCnt : st.perCnt + 8'h01;
         next_st.perCnt = 8'h00;
      end else if (st.perCnt != 8'hFF) begin
         next_st.perCnt = st.perCnt + 8'h01;
      end
      periodGood = (next_st.perMeas >= PER_LOW) && (next_st.perMeas <= PER_HIGH);

      // slot timing: slot k starts at ceil(k*period/7) cycles after the edge
      // the phase accumulator spreads the remainder so slots differ by one cycle at most
      if (!st.sdnS2) begin
         next_st.slot = 3'h0;
         next_st.acc = 8'h00;
         next_st.words = '0;
      end else if (pixEdge) begin
         next_st.slot = 3'h0;
         next_st.acc = 8'h00;
         for (int s = 0; s < SLOT_COUNT; s++) begin
            for (int l = 0; l < LANE_COUNT; l++) begin
               next_st.words[l][s] = st.dataPrev[SLOT_MAP[s][l]];
            end
         end
      end else if (st.slot != 3'(SLOT_COUNT - 1)) begin
         if (slotSum >= st.perMeas) begin
            next_st.slot = st.slot + 3'h1;
            next_st.acc = slotSum - st.perMeas;
         end else begin
            next_st.acc = slotSum;
         end
      end

      // lock: stable period for the lock time, entered only at a pixel edge
      // any bad period or stall restarts the whole lock time
      if (!st.sdnS2 || stalled || (pixEdge && !periodGood)) begin
         next_st.locked = 1'b0;
         next_st.lockCnt = 11'h000;
      end else if (st.lockCnt != LOCK_CYCLES) begin
         next_st.lockCnt = st.lockCnt + 11'h001;
      end else if (pixEdge) begin
         next_st.locked = 1'b1;
      end

      // registered pin values
      next_st.out.linkOeN = ~st.sdnS2;
      next_st.out.laneValid = next_st.locked;
      next_st.out.forwardedLinkClock =
         next_st.locked && (next_st.slot < 3'(FWD_HIGH_SLOTS));
      for (int l = 0; l < LANE_COUNT; l++) begin
         next_st.out.serialLaneOut[l] =
            next_st.locked & next_st.words[l][next_st.slot];
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         st <= '0;
         st.out.linkOeN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign linkOut = st.out;

   // copy of the loaded pixel, read only by the checks below
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         heldPixel <= '0;
      end else if (pixEdge && st.sdnS2) begin
         heldPixel <= st.dataPrev;
      end
   end

   // cycles spent in shutdown, saturating, read only by the checks below
   always_ff @(posedge ref_clk or negedge rstSync) begin
      if (!rstSync) begin
         quietCnt <= 4'h0;
      end else if (st.sdnS2) begin
         quietCnt <= 4'h0;
      end else if (quietCnt != 4'hF) begin
         quietCnt <= quietCnt + 4'h1;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstSync);

   // checks on slot timing and link clock shape
   a_slot_zero_rise: assert property ($rose(linkOut.forwardedLinkClock) |-> st.slot == 3'h0
   ) else $error("link clock rose outside slot 0");
   a_clock_high_slots: assert property (linkOut.laneValid |->
      (linkOut.forwardedLinkClock == (st.slot < 3'h4)))
      else $error("link clock level does not match slot");
   a_edge_restart: assert property (pixEdge && st.locked && st.sdnS2 && !stalled
      ##1 st.locked |-> st.slot == 3'h0 && linkOut.forwardedLinkClock)
      else $error("pixel edge did not restart the word");

   // checks on slot stepping between pixel edges
   a_slot_step: assert property (st.sdnS2 && !pixEdge && st.slot != 3'h6 |=>
      st.slot == $past(st.slot) || st.slot == $past(st.slot) + 3'h1)
      else $error("slot advanced by more than one");
   a_slot_last_hold: assert property (st.sdnS2 && !pixEdge && st.slot == 3'h6 |=>
      st.slot == 3'h6)
      else $error("slot 6 left before the next pixel edge");
   a_acc_bound: assert property (linkOut.laneValid |->
      st.acc < st.perMeas)
      else $error("slot phase accumulator out of range");

   // checks on loading a captured word
   a_edge_reload: assert property (pixEdge && st.sdnS2 |=>
      st.slot == 3'h0 && st.acc == 8'h00)
      else $error("pixel edge did not reload the slot timer");
   a_word_capture: assert property (pixEdge && st.sdnS2 |=>
      st.words[0][0] == $past(st.dataPrev[1]) && st.words[3][1] == $past(st.dataPrev[27]))
      else $error("captured word not loaded into the shift words");

   // checks on the bit map
   a_slot0_map: assert property (linkOut.laneValid && st.slot == 3'h0 |->
      linkOut.serialLaneOut == {heldPixel[5], heldPixel[20], heldPixel[9], heldPixel[1]})
      else $error("slot 0 lane bits wrong");
   a_slot1_map: assert property (linkOut.laneValid && st.slot == 3'h1 |->
      linkOut.serialLaneOut == {heldPixel[27], heldPixel[19], heldPixel[8], heldPixel[0]})
      else $error("slot 1 lane bits wrong");
   a_slot2_map: assert property (linkOut.laneValid && st.slot == 3'h2 |->
      linkOut.serialLaneOut == {heldPixel[23], heldPixel[26], heldPixel[18], heldPixel[7]})
      else $error("slot 2 lane bits wrong");
   a_slot3_map: assert property (linkOut.laneValid && st.slot == 3'h3 |->
      linkOut.serialLaneOut == {heldPixel[17], heldPixel[25], heldPixel[15], heldPixel[6]})
      else $error("slot 3 lane bits wrong");
   a_slot4_map: assert property (linkOut.laneValid && st.slot == 3'h4 |->
      linkOut.serialLaneOut == {heldPixel[16], heldPixel[24], heldPixel[14], heldPixel[4]})
      else $error("slot 4 lane bits wrong");
   a_slot5_map: assert property (linkOut.laneValid && st.slot == 3'h5 |->
      linkOut.serialLaneOut == {heldPixel[11], heldPixel[22], heldPixel[13], heldPixel[3]})
      else $error("slot 5 lane bits wrong");
   a_slot6_map: assert property (linkOut.laneValid && st.slot == 3'h6 |->
      linkOut.serialLaneOut == {heldPixel[10], heldPixel[21], heldPixel[12], heldPixel[2]})
      else $error("slot 6 lane bits wrong");

   // checks on shutdown, lock and the capture edge
   a_shutdown_float: assert property ($fell(st.sdnS2) |-> ##[0:DIS_BOUND] linkOut.linkOeN
   ) else $error("link outputs not floated after shutdown");
   a_shutdown_idle: assert property (!st.sdnS2 ##1 !st.sdnS2 |->
      !linkOut.laneValid && linkOut.serialLaneOut == 4'h0)
      else $error("lanes active during shutdown");
   a_lock_wait: assert property ($rose(linkOut.laneValid) |-> st.lockCnt == LOCK_CYCLES
   ) else $error("lane data valid before lock time");
   a_capture_edge: assert property (pixEdge |-> (st.selS2 ? st.clkS2 : !st.clkS2)
   ) else $error("capture on wrong pixel clock edge");

   // checks on the output enable
   a_enable_drives: assert property (st.sdnS2 |=>
      !linkOut.linkOeN)
      else $error("link outputs floated while enabled");
   a_disable_floats: assert property (!st.sdnS2 |=>
      linkOut.linkOeN)
      else $error("link outputs driven while shut down");

   // checks on idle lanes
   a_valid_enabled: assert property (linkOut.laneValid |->
      $past(st.sdnS2))
      else $error("lane data valid although shut down");
   a_idle_quiet: assert property (quietCnt >= 4'h2 |-> linkOut.linkOeN &&
      !linkOut.laneValid && !linkOut.forwardedLinkClock && linkOut.serialLaneOut == 4'h0)
      else $error("link not idle during a long shutdown");
   a_lane_zero: assert property (!linkOut.laneValid |->
      linkOut.serialLaneOut == 4'h0 && !linkOut.forwardedLinkClock)
      else $error("lanes active without valid data");
   a_shutdown_slot_idle: assert property (!st.sdnS2 |=>
      st.slot == 3'h0 && st.words == '0)
      else $error("serializer state not idle in shutdown");

   // checks on the lock timer
   a_timer_cleared: assert property (!st.sdnS2 |=>
      st.lockCnt == 11'h000 && !st.locked)
      else $error("lock timer kept running in shutdown");
   a_timer_bound: assert property (1'b1 |->
      st.lockCnt <= LOCK_CYCLES)
      else $error("lock timer ran past the lock time");
   a_lock_at_edge: assert property ($rose(linkOut.laneValid) |->
      $past(pixEdge))
      else $error("lock entered away from a pixel edge");
   a_whole_first_word: assert property ($rose(linkOut.laneValid) |->
      st.slot == 3'h0)
      else $error("first valid word did not start at slot 0");

   // checks on the period window and spread spectrum
   a_stall_unlock: assert property (stalled |=>
      !linkOut.laneValid)
      else $error("lane data valid without a pixel clock");
   a_bad_period_unlock: assert property (pixEdge && !periodGood |=>
      !linkOut.laneValid)
      else $error("lock kept on a period outside the window");
   a_period_window: assert property (linkOut.laneValid |->
      st.perMeas >= PER_LOW && st.perMeas <= PER_HIGH)
      else $error("lane data valid on a period outside the window");
   a_valid_steady: assert property (linkOut.laneValid && st.sdnS2 && !stalled && !pixEdge |=>
      linkOut.laneValid)
      else $error("lock lost between pixel edges");

   // checks on the link clock waveform
   a_fwd_falls_slot4: assert property ($fell(linkOut.forwardedLinkClock) && linkOut.laneValid |->
      st.slot == 3'h4)
      else $error("link clock fell outside slot 4");

   // main scenarios
   c_lock_reached: cover property ($rose(linkOut.laneValid));
   c_full_word: cover property (linkOut.laneValid && st.slot == 3'h6 ##1 st.slot == 3'h0);
   c_shutdown_live: cover property (linkOut.laneValid ##1 !st.sdnS2);
   c_falling_capture: cover property (pixEdge && !st.selS2 && st.locked);
   c_long_shutdown: cover property (quietCnt == 4'hF ##1 st.sdnS2);

endmodule

// >>> test/panel_rx_model.sv
// receiver model: samples the link lanes and rebuilds each 28-bit word
// assumes an 80 ns pixel period, that is PER sampling cycles per frame
`timescale 1ns/100ps
module panel_rx_model
   import lvds_serializer_pkg::*;
   #(parameter int PER = 20)
(
   // sampling clock
   input wire logic ref_clk,
   // link from the serializer
   input wire lvds_serializer_pkg::link_out_t linkOut,
   // rebuilt word and frame figures
   output lvds_serializer_pkg::pixel_t rxWord,
   output logic rxStrobe,
   output logic [7:0] hiCount,
   output logic [7:0] perCount
);
   import lvds_serializer_pkg::*;
   logic [7:0] cnt = 8'h00;
   logic [7:0] hiRun = 8'h00;
   logic clkPrev = 1'b0;
   pixel_t acc;

   // a rising link clock opens slot 0; slot k is read one cycle after ceil(PER*k/7)
   always_ff @(posedge ref_clk) begin
      logic rise;
      int idx;
      rise = linkOut.forwardedLinkClock && !clkPrev;
      idx = rise ? 0 : int'(cnt);
      clkPrev <= linkOut.forwardedLinkClock;
      cnt <= rise ? 8'h01 : cnt + 8'h01;
      rxStrobe <= rise;
      if (rise) begin
         rxWord <= acc;
         perCount <= cnt; // same period as the pixel clock
         hiCount <= hiRun; // high for four of the seven slots
         hiRun <= 8'h01;
      end else begin
         hiRun <= hiRun + {7'h00, linkOut.forwardedLinkClock};
      end
      // each lane bit lands where the slot map puts it
      for (int k = 0; k < SLOT_COUNT; k++) begin
         if (idx == (PER * k + 6) / 7 + 1) begin
            for (int l = 0; l < LANE_COUNT; l++) begin
               acc[SLOT_MAP[k][l]] <= linkOut.serialLaneOut[l];
            end
         end
      end
   end
endmodule

// >>> test/test_lvds_seven_to_one_serializer.sv
// self-checking bench for the 7:1 pixel serializer with a panel receiver model
// assumes the design package and the receiver model are compiled first
`timescale 1ns/100ps
module test_lvds_seven_to_one_serializer;
   import lvds_serializer_pkg::*;
   logic ref_clk, rst_n, pixelClockIn, captureEdgeSelect, shutdownN, rxStrobe;
   pixel_t parallelPixelBits, nextWord, rxWord;
   link_out_t linkOut;
   logic [7:0] hiCount, perCount;
   int mismatches, compares, phase;

   lvds_seven_to_one_serializer u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .pixelClockIn(pixelClockIn), .parallelPixelBits(parallelPixelBits),
      .captureEdgeSelect(captureEdgeSelect), .shutdownN(shutdownN), .linkOut(linkOut));
   panel_rx_model #(.PER(20)) u_rx (.ref_clk(ref_clk), .linkOut(linkOut),
      .rxWord(rxWord), .rxStrobe(rxStrobe), .hiCount(hiCount), .perCount(perCount));

   // 250 MHz sampling clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // 80 ns pixel clock; a new word is laid on at the edge that does not capture
   always @(negedge ref_clk) begin
      phase <= (phase == 9) ? 0 : phase + 1;
      if (phase == 9) begin
         pixelClockIn <= ~pixelClockIn;
         if (pixelClockIn == captureEdgeSelect) begin
            parallelPixelBits <= nextWord;
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] expected);
      compares++;
      if (seen !== expected) begin
         mismatches++;
         $display("[ERR] %0t ns: seen %h, expected %h", $time, seen, expected);
      end
   endtask

   task automatic conclude();
      $display("mismatches %0d, compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic timedOut();
      mismatches++;
      $display("[ERR] %0t ns: wait ran out", $time);
      conclude();
   endtask

   // wait for lane data to turn valid, returning the cycles taken
   task automatic waitValid(output int t);
      for (t = 0; t < 3000 && linkOut.laneValid !== 1'b1; t++) begin
         @(negedge ref_clk);
      end
      if (t == 3000) timedOut();
   endtask

   // wait for n whole frames seen by the receiver
   task automatic waitFrames(input int n);
      int got;
      got = 0;
      for (int t = 0; t < 40 * n && got < n; t++) begin
         @(negedge ref_clk);
         if (rxStrobe === 1'b1) got++;
      end
      if (got < n) timedOut();
   endtask

   // hold a word on the pins until whole frames of it have been received
   task automatic sendWord(input pixel_t w);
      nextWord = w;
      waitFrames(4);
      check(rxWord, w);
   endtask

   task automatic lockUp();
      int t;
      shutdownN = 1'b1;
      waitValid(t);
      check(t >= 1500, 1);
      check(linkOut.linkOeN, 1'b0);
   endtask

   // a single one and a single zero walked across all 28 bits
   task automatic walkBits();
      for (int b = 0; b < PIXEL_BITS; b++) begin
         sendWord(pixel_t'(1) << b);
         sendWord(~(pixel_t'(1) << b));
      end
      check(perCount, 8'h14);
      check(hiCount, 8'h0C);
   endtask

   // capture moves to the falling pixel edge
   task automatic edgeFall();
      int t;
      captureEdgeSelect = 1'b0;
      repeat (40) @(negedge ref_clk);
      waitValid(t);
      sendWord(28'h5A5_C3F1);
      sendWord(28'hA5A_3C0E);
   endtask

   task automatic shutDown();
      int t;
      shutdownN = 1'b0;
      for (t = 0; t < 10 && linkOut.linkOeN !== 1'b1; t++) begin
         @(negedge ref_clk);
      end
      check(t <= 5, 1);
      check(linkOut.laneValid, 1'b0);
      repeat (40) @(negedge ref_clk);
      check({linkOut.serialLaneOut, linkOut.forwardedLinkClock}, 5'h00);
   endtask

   initial begin
      rst_n = 1'b0;
      pixelClockIn = 1'b0;
      captureEdgeSelect = 1'b1;
      shutdownN = 1'b0;
      nextWord = '0;
      parallelPixelBits = '0;
      phase = 0;
      mismatches = 0;
      compares = 0;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(linkOut.linkOeN, 1'b1);
      lockUp();
      walkBits();
      edgeFall();
      shutDown();
      lockUp();
      sendWord(28'h0F0_1234);
      conclude();
   end
endmodule
